/* include/pps_pkg.sv */
// Purpose: Shared constants, types and helpers of the pulse sequencer
// Assumes: Single 100 MHz core clock
// Notes:   Instruction fields, opcodes, states and timing counts
package pps_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned MIN_INSTR_CYC   = 6;
  localparam int unsigned WAIT_LAT_CYC    = 8;
  localparam int unsigned WAIT_EXT_MAX_S  = 40;
  localparam logic [31:0] WAIT_EXT_MAX_CYC =
    32'(64'(WAIT_EXT_MAX_S) * 64'(CLK_HZ));

  // ==========================================================
  // Instruction word
  localparam int unsigned INSTR_W   = 80;
  localparam int unsigned ADDR_W    = 12;
  localparam int unsigned MEM_DEPTH = 4096;
  localparam int unsigned PAT_LSB   = 56;
  localparam int unsigned PAT_W     = 24;
  localparam int unsigned OPC_LSB   = 52;
  localparam int unsigned OPC_W     = 4;
  localparam int unsigned ARG_LSB   = 32;
  localparam int unsigned ARG_W     = 20;
  localparam int unsigned DLY_LSB   = 0;
  localparam int unsigned DLY_W     = 32;
  localparam int unsigned LONG_W    = 52;
  localparam int unsigned CNT_W     = 53;
  localparam int unsigned NARROW_W  = 12;
  localparam int unsigned STK_DEPTH = 8;
  localparam int unsigned STK_NW    = 4;

  // ==========================================================
  // Opcodes
  localparam logic [3:0] OP_CONT   = 4'h0;
  localparam logic [3:0] OP_STOP   = 4'h1;
  localparam logic [3:0] OP_LOOP   = 4'h2;
  localparam logic [3:0] OP_ENDLP  = 4'h3;
  localparam logic [3:0] OP_CALL   = 4'h4;
  localparam logic [3:0] OP_RET    = 4'h5;
  localparam logic [3:0] OP_BRANCH = 4'h6;
  localparam logic [3:0] OP_LONG   = 4'h7;
  localparam logic [3:0] OP_WAIT   = 4'h8;

  // ==========================================================
  // Status bits
  localparam int unsigned STS_W       = 5;
  localparam int unsigned STS_STOPPED = 0;
  localparam int unsigned STS_RESET   = 1;
  localparam int unsigned STS_RUNNING = 2;
  localparam int unsigned STS_WAITING = 3;
  localparam int unsigned STS_FAULT   = 4;

  // ==========================================================
  // Sequencer states
  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_FETCH  = 7'h02,
    ST_DECODE = 7'h04,
    ST_DELAY  = 7'h08,
    ST_WTRIG  = 7'h10,
    ST_WLAT   = 7'h20,
    ST_HALT   = 7'h40
  } pps_state_e;

  // ==========================================================
  // Duration in cycles; zero means full range, floor of six
  function automatic logic [52:0] pps_dur(input logic [51:0] v,
                                          input logic        lng);
    logic [52:0] d;
    d = '0;
    if (lng) begin
      d = (v == '0) ? 53'h10000000000000 : {1'b0, v};
    end else begin
      d = (v[31:0] == '0) ? 53'h00000100000000 : {21'h0, v[31:0]};
    end
    if (d < 53'(MIN_INSTR_CYC)) begin
      d = 53'(MIN_INSTR_CYC);
    end
    return d;
  endfunction : pps_dur

endpackage : pps_pkg

/* include/pps_core_if.sv */
// Purpose: Links the sequencer to its stacks and program memory
// Assumes: All signals on clk_sys
// Notes:   Stack tops and memory data are driven by the leaves
`timescale 1ns/1ps
`default_nettype none
interface pps_core_if;
  logic        clr;
  logic        lp_push;
  logic        lp_pop;
  logic        lp_dec;
  logic [11:0] lp_waddr;
  logic [19:0] lp_wrem;
  logic [11:0] lp_addr;
  logic [19:0] lp_rem;
  logic        lp_full;
  logic        lp_empty;
  logic        cs_push;
  logic        cs_pop;
  logic [11:0] cs_wdata;
  logic [11:0] cs_top;
  logic        cs_full;
  logic        cs_empty;
  logic        mem_we;
  logic [11:0] mem_waddr;
  logic [79:0] mem_wdata;
  logic [11:0] mem_raddr;
  logic [79:0] mem_rdata;

  modport seq (output clr, lp_push, lp_pop, lp_dec, lp_waddr, lp_wrem,
               cs_push, cs_pop, cs_wdata, mem_we, mem_waddr, mem_wdata,
               mem_raddr,
               input  lp_addr, lp_rem, lp_full, lp_empty, cs_top,
               cs_full, cs_empty, mem_rdata);
  modport stk (input  clr, lp_push, lp_pop, lp_dec, lp_waddr, lp_wrem,
               cs_push, cs_pop, cs_wdata,
               output lp_addr, lp_rem, lp_full, lp_empty, cs_top,
               cs_full, cs_empty);
  modport mem (input  mem_we, mem_waddr, mem_wdata, mem_raddr,
               output mem_rdata);
endinterface : pps_core_if
`default_nettype wire

/* core/pps_prog_mem.sv */
// Purpose: Program memory, one write port and one registered read
// Assumes: Host writes while the sequencer is idle
// Notes:   Read data appears one cycle after the address
`timescale 1ns/1ps
`default_nettype none
module pps_prog_mem
  import pps_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  pps_core_if.mem   cif
);

  // ==========================================================
  // Storage
  logic [79:0] mem_r [MEM_DEPTH];
  logic [79:0] rd_q;

  always_ff @(posedge clk_sys) begin
    if (cif.mem_we) begin
      mem_r[cif.mem_waddr] <= cif.mem_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rd_q <= '0;
    end else begin
      rd_q <= mem_r[cif.mem_raddr];
    end
  end

  assign cif.mem_rdata = rd_q;

  // ==========================================================
  // Checks
  a_mem_readback: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (cif.mem_we && cif.mem_raddr == cif.mem_waddr) ##1
    (!cif.mem_we && cif.mem_raddr == $past(cif.mem_waddr))
    |=> rd_q == $past(cif.mem_wdata, 2))
    else $error("program word not read back");

endmodule : pps_prog_mem
`default_nettype wire

/* core/pps_stacks.sv */
// Purpose: Loop stack and call stack, eight levels each
// Assumes: Sequencer never pushes when full or pops when empty
// Notes:   Tops are combinational from the stored entries
`timescale 1ns/1ps
`default_nettype none
module pps_stacks
  import pps_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  pps_core_if.stk   cif
);

  typedef struct packed {
    logic [7:0][31:0] lp;
    logic [3:0]       lp_n;
    logic [7:0][11:0] cs;
    logic [3:0]       cs_n;
  } pps_stk_s;

  pps_stk_s s_q;
  pps_stk_s s_d;
  logic [2:0] lp_top;
  logic [2:0] cs_top;

  assign lp_top = 3'(s_q.lp_n - 4'h1);
  assign cs_top = 3'(s_q.cs_n - 4'h1);

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    if (cif.clr) begin
      s_d.lp_n = '0;
      s_d.cs_n = '0;
    end else begin
      if (cif.lp_push && s_q.lp_n != 4'(STK_DEPTH)) begin
        s_d.lp[s_q.lp_n[2:0]] = {cif.lp_waddr, cif.lp_wrem};
        s_d.lp_n = s_q.lp_n + 4'h1;
      end else if (cif.lp_pop && s_q.lp_n != '0) begin
        s_d.lp_n = s_q.lp_n - 4'h1;
      end else if (cif.lp_dec && s_q.lp_n != '0) begin
        s_d.lp[lp_top][19:0] = s_q.lp[lp_top][19:0] - 20'h1;
      end
      if (cif.cs_push && s_q.cs_n != 4'(STK_DEPTH)) begin
        s_d.cs[s_q.cs_n[2:0]] = cif.cs_wdata;
        s_d.cs_n = s_q.cs_n + 4'h1;
      end else if (cif.cs_pop && s_q.cs_n != '0) begin
        s_d.cs_n = s_q.cs_n - 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign cif.lp_addr  = s_q.lp[lp_top][31:20];
  assign cif.lp_rem   = s_q.lp[lp_top][19:0];
  assign cif.lp_full  = (s_q.lp_n == 4'(STK_DEPTH));
  assign cif.lp_empty = (s_q.lp_n == '0);
  assign cif.cs_top   = s_q.cs[cs_top];
  assign cif.cs_full  = (s_q.cs_n == 4'(STK_DEPTH));
  assign cif.cs_empty = (s_q.cs_n == '0);

  // ==========================================================
  // Checks
  a_loop_depth: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!cif.clr && cif.lp_push && s_q.lp_n < 4'h8)
    |=> s_q.lp_n == $past(s_q.lp_n) + 4'h1 && !cif.lp_empty)
    else $error("loop level not added");

  a_call_lifo: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!cif.clr && cif.cs_push && !cif.cs_full)
    |=> cif.cs_top == $past(cif.cs_wdata))
    else $error("call return address lost");

endmodule : pps_stacks
`default_nettype wire

/* core/pps_top.sv */
// Purpose: Pulse pattern sequencer core
// Assumes: Program loaded by the host bus controller while idle
// Notes:   Trigger and stop pins are synchronised here
`timescale 1ns/1ps
`default_nettype none
module pps_top
  import pps_pkg::*;
#(
  parameter logic        NARROW_VARIANT = 1'b0,
  parameter logic [31:0] WAIT_EXT_MAX   = WAIT_EXT_MAX_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        prog_we,
  input  wire logic [11:0] prog_addr,
  input  wire logic [79:0] prog_wdata,
  input  wire logic        sw_start,
  input  wire logic        sw_stop,
  output logic      [4:0]  host_status,
  input  wire logic        hw_trig,
  input  wire logic        hw_stop,
  output logic      [23:0] flag_out,
  output logic      [4:0]  status_out
);

  typedef struct packed {
    pps_state_e  st;
    logic [11:0] pc;
    logic [52:0] cnt;
    logic [23:0] pat;
    logic [4:0]  sts;
    logic        flt;
    logic        trg_m;
    logic        trg_s;
    logic        trg_d;
    logic        stp_m;
    logic        stp_s;
  } pps_top_s;

  pps_top_s s_q;
  pps_top_s s_d;

  pps_core_if cif ();

  // ==========================================================
  // Leaves
  pps_prog_mem u_mem (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .cif     (cif.mem)
  );

  pps_stacks u_stk (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .cif     (cif.stk)
  );

  // ==========================================================
  // Instruction fields
  logic [23:0] f_pat;
  logic [3:0]  f_op;
  logic [19:0] f_arg;
  logic [31:0] f_dly;
  logic [23:0] out_mask;
  logic        go;
  logic        stop;
  logic [31:0] wext;

  assign f_pat = cif.mem_rdata[PAT_LSB +: PAT_W];
  assign f_op  = cif.mem_rdata[OPC_LSB +: OPC_W];
  assign f_arg = cif.mem_rdata[ARG_LSB +: ARG_W];
  assign f_dly = cif.mem_rdata[DLY_LSB +: DLY_W];
  assign out_mask = NARROW_VARIANT ? 24'h000fff : 24'hffffff;
  assign go   = (s_q.trg_s & ~s_q.trg_d) | sw_start;
  assign stop = s_q.stp_s | sw_stop;
  assign wext = (f_dly > WAIT_EXT_MAX) ? WAIT_EXT_MAX : f_dly;

  assign cif.mem_we    = prog_we;
  assign cif.mem_waddr = prog_addr;
  assign cif.mem_wdata = prog_wdata;
  assign cif.mem_raddr = s_q.pc;

  // ==========================================================
  // Sequencer
  always_comb begin
    s_d = s_q;
    cif.clr      = 1'b0;
    cif.lp_push  = 1'b0;
    cif.lp_pop   = 1'b0;
    cif.lp_dec   = 1'b0;
    cif.lp_waddr = 12'(s_q.pc + 12'h1);
    cif.lp_wrem  = f_arg - 20'h1;
    cif.cs_push  = 1'b0;
    cif.cs_pop   = 1'b0;
    cif.cs_wdata = 12'(s_q.pc + 12'h1);
    s_d.trg_m = hw_trig;
    s_d.trg_s = s_q.trg_m;
    s_d.trg_d = s_q.trg_s;
    s_d.stp_m = hw_stop;
    s_d.stp_s = s_q.stp_m;
    case (s_q.st)
      ST_IDLE: begin
        if (go) begin
          s_d.st = ST_FETCH;
        end
      end
      ST_FETCH: begin
        s_d.st = ST_DECODE;
      end
      ST_DECODE: begin
        s_d.pat = f_pat & out_mask;
        s_d.pc  = 12'(s_q.pc + 12'h1);
        s_d.cnt = 53'(pps_dur({20'h0, f_dly}, 1'b0) - 53'h2);
        s_d.st  = ST_DELAY;
        case (f_op)
          OP_STOP: begin
            s_d.st = ST_HALT;
          end
          OP_LONG: begin
            s_d.cnt = 53'(pps_dur({f_arg, f_dly}, 1'b1) - 53'h2);
          end
          OP_BRANCH: begin
            s_d.pc = f_arg[11:0];
          end
          OP_CALL: begin
            if (cif.cs_full) begin
              s_d.flt = 1'b1;
              s_d.st  = ST_HALT;
            end else begin
              cif.cs_push = 1'b1;
              s_d.pc = f_arg[11:0];
            end
          end
          OP_RET: begin
            if (cif.cs_empty) begin
              s_d.flt = 1'b1;
              s_d.st  = ST_HALT;
            end else begin
              cif.cs_pop = 1'b1;
              s_d.pc = cif.cs_top;
            end
          end
          OP_LOOP: begin
            if (cif.lp_full) begin
              s_d.flt = 1'b1;
              s_d.st  = ST_HALT;
            end else begin
              cif.lp_push = 1'b1;
            end
          end
          OP_ENDLP: begin
            if (cif.lp_empty) begin
              s_d.flt = 1'b1;
              s_d.st  = ST_HALT;
            end else if (cif.lp_rem != '0) begin
              cif.lp_dec = 1'b1;
              s_d.pc = cif.lp_addr;
            end else begin
              cif.lp_pop = 1'b1;
            end
          end
          OP_WAIT: begin
            s_d.cnt = {21'h0, wext};
            s_d.st = ST_WTRIG;
          end
          default: begin
          end
        endcase
      end
      ST_DELAY, ST_WLAT: begin
        if (s_q.cnt == '0) begin
          s_d.st = ST_DECODE;
        end else begin
          s_d.cnt = s_q.cnt - 53'h1;
        end
      end
      ST_WTRIG: begin
        if (go) begin
          s_d.cnt = 53'(WAIT_LAT_CYC - 2) + s_q.cnt;
          s_d.st  = ST_WLAT;
        end
      end
      ST_HALT: begin
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
    if (stop) begin
      s_d.st  = ST_IDLE;
      s_d.pc  = '0;
      s_d.pat = '0;
      s_d.flt = 1'b0;
      cif.clr = 1'b1;
    end
    s_d.sts = '0;
    s_d.sts[STS_STOPPED] = (s_d.st == ST_HALT);
    s_d.sts[STS_RESET]   = (s_d.st == ST_IDLE);
    s_d.sts[STS_RUNNING] = (s_d.st == ST_FETCH) || (s_d.st == ST_DECODE) ||
                           (s_d.st == ST_DELAY) || (s_d.st == ST_WLAT);
    s_d.sts[STS_WAITING] = (s_d.st == ST_WTRIG);
    s_d.sts[STS_FAULT]   = s_d.flt;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_q <= '{st: ST_IDLE, sts: 5'h02, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign flag_out    = s_q.pat;
  assign status_out  = s_q.sts;
  assign host_status = s_q.sts;

  // ==========================================================
  // Check helpers
  logic [52:0] gap_q;
  logic [52:0] exp_q;
  logic        tmd_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      gap_q <= '0;
      exp_q <= '0;
      tmd_q <= 1'b0;
    end else if (s_q.st == ST_DECODE) begin
      gap_q <= 53'h1;
      exp_q <= pps_dur({(f_op == OP_LONG) ? f_arg : 20'h0, f_dly},
                       f_op == OP_LONG);
      tmd_q <= (s_d.st == ST_DELAY);
    end else begin
      gap_q <= gap_q + 53'h1;
      if (s_q.st == ST_IDLE) begin
        tmd_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_instr_min_len: assert property (
    s_q.st == ST_DECODE |=> (s_q.st != ST_DECODE) [*5])
    else $error("instruction shorter than six clocks");

  a_delay_exact: assert property (
    (s_q.st == ST_DECODE && tmd_q && !$past(stop)) |-> gap_q == exp_q)
    else $error("instruction length differs from its count");

  a_wait_latency: assert property (
    (s_q.st == ST_WTRIG && go && !stop && s_q.cnt == '0)
    |-> ##1 (!stop [*7]) |=> s_q.st == ST_DECODE)
    else $error("wait did not resume after eight clocks");

  a_stop_reset: assert property (
    stop |=> s_q.st == ST_IDLE && s_q.pc == '0 && flag_out == '0)
    else $error("stop did not reset the program");

  a_out_pattern: assert property (
    (s_q.st == ST_DECODE && !stop) |=> flag_out == ($past(f_pat) & out_mask))
    else $error("outputs do not follow the pattern");

  a_narrow_bits: assert property (
    NARROW_VARIANT |-> flag_out[23:12] == '0)
    else $error("narrow variant drives high bits");

  a_status_run: assert property (
    (s_q.st == ST_DELAY) |-> status_out[STS_RUNNING] && !status_out[STS_RESET]
    && host_status == status_out)
    else $error("status does not show running");

  a_branch_target: assert property (
    (s_q.st == ST_DECODE && f_op == OP_BRANCH && !stop)
    |=> s_q.pc == $past(f_arg[11:0]))
    else $error("branch went to the wrong address");

endmodule : pps_top
`default_nettype wire

/* tb/pps_host_model.sv */
// Purpose: Host side and trigger source driving the sequencer pins
// Assumes: Bus controller reduced to a word write port and start/stop
// Notes:   Starts and triggers are spaced at least twenty clocks apart
`timescale 1ns/1ps
`default_nettype none
module pps_host_model (
  input  wire logic        clk_sys,
  output logic             prog_we,
  output logic      [11:0] prog_addr,
  output logic      [79:0] prog_wdata,
  output logic             sw_start,
  output logic             sw_stop,
  output logic             hw_trig,
  output logic             hw_stop
);
  int cyc = 0;
  int last_trig = -100;

  initial begin
    prog_we = 1'b0;
    prog_addr = 12'h000;
    prog_wdata = '0;
    {sw_start, sw_stop, hw_trig, hw_stop} = 4'h0;
  end

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
  end

  // ================================================
  // Program load, one whole word per strobe
  task automatic write_word(input logic [11:0] a, input logic [79:0] d);
    @(posedge clk_sys);
    #1;
    prog_we = 1'b1;
    prog_addr = a;
    prog_wdata = d;
    @(posedge clk_sys);
    #1;
    prog_we = 1'b0;
    prog_addr = ~a;
    prog_wdata = ~d;
  endtask : write_word

  // ================================================
  // Control lines: 0 start, 1 stop, 2 trigger pin, 3 stop pin
  task automatic pulse(input int which, input int n);
    if (which == 0 || which == 2) begin
      while (cyc - last_trig < 20) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    #1;
    case (which)
      0: sw_start = 1'b1;
      1: sw_stop = 1'b1;
      2: hw_trig = 1'b1;
      default: hw_stop = 1'b1;
    endcase
    if (which == 0 || which == 2) begin
      last_trig = cyc + 1;
    end
    repeat (n) @(posedge clk_sys);
    #1;
    {sw_start, sw_stop, hw_trig, hw_stop} = 4'h0;
  endtask : pulse
endmodule : pps_host_model
`default_nettype wire

/* tb/test_pulse_pattern_sequencer.sv */
// Purpose: Self-checking bench for the pulse pattern sequencer
// Assumes: Host model drives all inputs but clock and reset one ns after the rising edge
// Notes:   Wait extension ceiling of twenty clocks on both instances
`timescale 1ns/1ps
`default_nettype none
module test_pulse_pattern_sequencer
  import pps_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        prog_we, sw_start, sw_stop, hw_trig, hw_stop;
  logic [11:0] prog_addr;
  logic [79:0] prog_wdata;
  logic [4:0]  host_status, status_out;
  logic [23:0] flag_out, flag_n;
  logic [23:0] last_flag = '0;
  logic [23:0] ch_val[$];
  int          ch_cyc[$];
  int          cyc = 0;
  int          bad_count = 0;
  int          tests_run = 0;

  always #5 clk_sys = ~clk_sys;

  pps_host_model host (.clk_sys(clk_sys), .prog_we(prog_we),
    .prog_addr(prog_addr), .prog_wdata(prog_wdata), .sw_start(sw_start),
    .sw_stop(sw_stop), .hw_trig(hw_trig), .hw_stop(hw_stop));
  pps_top #(.WAIT_EXT_MAX(32'h00000014)) dut (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .prog_we(prog_we), .prog_addr(prog_addr),
    .prog_wdata(prog_wdata), .sw_start(sw_start), .sw_stop(sw_stop),
    .host_status(host_status), .hw_trig(hw_trig), .hw_stop(hw_stop),
    .flag_out(flag_out), .status_out(status_out));
  pps_top #(.NARROW_VARIANT(1'b1), .WAIT_EXT_MAX(32'h00000014)) dut_n (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .prog_we(prog_we),
    .prog_addr(prog_addr), .prog_wdata(prog_wdata), .sw_start(sw_start),
    .sw_stop(sw_stop), .host_status(), .hw_trig(hw_trig),
    .hw_stop(hw_stop), .flag_out(flag_n), .status_out());

  // ================================================
  // Checking and closing
  task automatic chk(input string nm, input logic [63:0] seen,
                     input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  // Cycle count, hang limit and record of pattern changes
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc > 5000) begin
      bad_count++;
      wrap_up();
    end
  end

  always @(posedge clk_sys) begin
    #2;
    if (flag_out !== last_flag) begin
      ch_cyc.push_back(cyc);
      ch_val.push_back(flag_out);
      last_flag = flag_out;
      chk("narrow", 64'(flag_n), 64'({12'h000, flag_out[11:0]}));
    end
  end

  // ================================================
  // Helpers
  function automatic logic [79:0] ins(input logic [23:0] p,
    input logic [3:0] op, input int arg, input int d);
    return {p, op, arg[19:0], d[31:0]};
  endfunction : ins

  function automatic int chg(input logic [23:0] v);
    foreach (ch_val[i]) begin
      if (ch_val[i] === v) return ch_cyc[i];
    end
    return -1;
  endfunction : chg

  task automatic restart();
    host.pulse(1, 2);
    repeat (3) @(posedge clk_sys);
    #2;
    chk("stop_sts", 64'(status_out), 64'h02);
    chk("stop_flag", 64'(flag_out), 64'h0);
    ch_cyc.delete();
    ch_val.delete();
  endtask : restart

  task automatic run(input int n);
    host.pulse(0, 1);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : run

  task automatic seq_chk(input int e[$]);
    chk("seq_len", 64'(ch_val.size()), 64'(e.size()));
    foreach (e[i]) chk("seq_val", 64'(ch_val[i]), 64'(e[i]));
  endtask : seq_chk

  task automatic wait_bit(input int b);
    int n;
    n = 0;
    while (status_out[b] !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      #2;
      n++;
    end
    chk("sts_bit", 64'(status_out[b]), 64'h1);
  endtask : wait_bit

  // ================================================
  // Scenarios
  task automatic t_timing();
    int t0;
    restart();
    host.write_word(12'h000, ins(24'ha5c3f1, OP_CONT, 0, 6));
    host.write_word(12'h001, ins(24'h5a3c0e, OP_CONT, 0, 3));
    host.write_word(12'h002, ins(24'h0f0f0f, OP_LONG, 0, 9));
    host.write_word(12'h003, ins(24'hf0f0f0, OP_CONT, 0, 13));
    host.write_word(12'h004, ins(24'h123456, OP_CONT, 0, 6));
    host.write_word(12'h005, ins(24'h123456, OP_STOP, 0, 6));
    host.pulse(0, 1);
    t0 = cyc - 1;
    repeat (60) @(posedge clk_sys);
    #2;
    chk("start_lat", 64'(ch_cyc[0] - t0), 64'd3);
    chk("dur_6", 64'(ch_cyc[1] - ch_cyc[0]), 64'd6);
    chk("dur_min", 64'(ch_cyc[2] - ch_cyc[1]), 64'd6);
    chk("dur_long", 64'(ch_cyc[3] - ch_cyc[2]), 64'd9);
    chk("dur_13", 64'(ch_cyc[4] - ch_cyc[3]), 64'd13);
    chk("pattern", 64'(ch_val[3]), 64'hf0f0f0);
    chk("halted", 64'(status_out[STS_STOPPED]), 64'h1);
    chk("host_sts", 64'(host_status), 64'h01);
  endtask : t_timing

  task automatic t_loop_branch();
    restart();
    host.write_word(12'h000, ins(24'h1, OP_LOOP, 3, 6));
    host.write_word(12'h001, ins(24'h2, OP_CONT, 0, 6));
    host.write_word(12'h002, ins(24'h3, OP_ENDLP, 0, 6));
    host.write_word(12'h003, ins(24'h4, OP_BRANCH, 'hfff, 6));
    host.write_word(12'h004, ins(24'h55, OP_STOP, 0, 6));
    host.write_word(12'hfff, ins(24'h6, OP_BRANCH, 5, 6));
    host.write_word(12'h005, ins(24'h6, OP_STOP, 0, 6));
    run(100);
    seq_chk({1, 2, 3, 2, 3, 2, 3, 4, 6});
  endtask : t_loop_branch

  task automatic t_calls();
    restart();
    host.write_word(12'h000, ins(24'h1, OP_CALL, 4, 6));
    host.write_word(12'h001, ins(24'h2, OP_CALL, 4, 6));
    host.write_word(12'h002, ins(24'h3, OP_CONT, 0, 6));
    host.write_word(12'h003, ins(24'h3, OP_STOP, 0, 6));
    host.write_word(12'h004, ins(24'h8, OP_CONT, 0, 6));
    host.write_word(12'h005, ins(24'h9, OP_RET, 0, 6));
    run(80);
    seq_chk({1, 8, 9, 2, 8, 9, 3});
    restart();
    host.write_word(12'h000, ins(24'h1, OP_RET, 0, 6));
    run(30);
    chk("fault", 64'(status_out[STS_FAULT]), 64'h1);
  endtask : t_calls

  task automatic t_wait();
    int t0, t1;
    restart();
    host.write_word(12'h000, ins(24'h1, OP_CONT, 0, 6));
    host.write_word(12'h001, ins(24'h1, OP_WAIT, 0, 0));
    host.write_word(12'h002, ins(24'h2, OP_CONT, 0, 6));
    host.write_word(12'h003, ins(24'h2, OP_WAIT, 0, 30));
    host.write_word(12'h004, ins(24'h3, OP_CONT, 0, 6));
    host.write_word(12'h005, ins(24'h3, OP_STOP, 0, 6));
    run(0);
    wait_bit(STS_WAITING);
    host.pulse(0, 1);
    t0 = cyc - 1;
    wait_bit(STS_WAITING);
    host.pulse(0, 1);
    t1 = cyc - 1;
    repeat (60) @(posedge clk_sys);
    chk("wait_lat", 64'(chg(24'h2) - t0), 64'd9);
    chk("wait_ext", 64'(chg(24'h3) - t1), 64'd29);
  endtask : t_wait

  task automatic t_hw_pins();
    int d;
    restart();
    host.write_word(12'h000, ins(24'h00abcd, OP_CONT, 0, 6));
    host.write_word(12'h001, ins(24'h00abcd, OP_STOP, 0, 6));
    host.pulse(2, 3);
    d = cyc - 3;
    repeat (20) @(posedge clk_sys);
    d = chg(24'h00abcd) - d;
    chk("trig_go", 64'(d >= 4 && d <= 7), 64'h1);
    host.pulse(3, 3);
    repeat (4) @(posedge clk_sys);
    #2;
    chk("pin_stop", 64'(status_out), 64'h02);
    chk("pin_flag", 64'(flag_out), 64'h0);
  endtask : t_hw_pins

  initial begin
    repeat (8) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    #1;
    chk("rst_sts", 64'(status_out), 64'h02);
    chk("rst_flag", 64'(flag_out), 64'h0);
    t_timing();
    t_loop_branch();
    t_calls();
    t_wait();
    t_hw_pins();
    wrap_up();
  end
endmodule : test_pulse_pattern_sequencer
`default_nettype wire
